// ---- core/spf_ctrl.sv ----
// self-programming flash control: command arming, page buffer, busy tracking
//
// Overview of operation
// - top 32 pages are no-read-while-write, lower 224 pages read-while-write.
// - program counter is 14 bits, bit 13 most significant.
// - a page holds 64 words; low six counter bits pick the word.
// - erase and write take the page from pointer bits 14 to 7.
// - pointer bits 6 to 1 pick the buffer word; zero for page write.
// - pointer bit 15 is ignored by every operation.
// - ready interrupt asserts while enable, global flag set and enable clear.
// - erase or write of read-while-write section sets busy and blocks it.
// - busy clears on re-enable after completion or on a buffer fill.
// - re-enable plus store within four clocks reopens section, not while busy.
// - re-enable written during buffer loading discards all buffered data.
// - lock-set plus store within four clocks writes lock byte from low data.
// - load within three cycles of lock-set returns lock or fuse byte.
// - page-write plus store within four clocks writes buffer to page.
// - page-erase plus store within four clocks erases addressed page.
// - cpu stalls during erase or write aimed at no-read-while-write section.
// - enable alone plus store puts data pair into selected buffer word.
// - enable arms four clocks, clears on store or lapse, holds while busy.
// - only the five listed low-bit patterns take effect on a write.
// - each erase, write or lock write lasts within the programming time.
`timescale 1ns/100ps
`include "spf_consts.svh"

module spf_ctrl #(
    parameter int PROG_CYCLES = `SPF_PROG_CYCLES,
    parameter logic [7:0] FUSE_LOW = 8'hff,
    parameter logic [7:0] FUSE_HIGH = 8'hd9
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // register port
    input wire spf_pkg::spf_reg_req_s i_reg,
    output logic [7:0] o_rdata,
    // cpu side
    input wire spf_pkg::spf_cpu_req_s i_cpu,
    input wire logic i_global_irq_en,
    input wire logic [1:0] i_boot_size_select,
    output logic o_cpu_stall,
    output logic o_ready_irq,
    output logic o_lpm_special,
    output logic [7:0] o_lpm_data,
    output logic o_rww_blocked,
    output logic [13:0] o_boot_reset_addr,
    // flash array side
    output spf_pkg::spf_flash_op_s o_flash_op,
    output logic [15:0] o_flash_wdata,
    output logic [5:0] o_flash_word,
    output logic o_lock_wr,
    output logic [7:0] o_lock_byte
);
    import spf_pkg::*;

    localparam int PW = $clog2(`SPF_PAGE_WORDS);

    spf_state_e state;
    spf_op_e op;
    logic irq_en;
    logic busy_flag;
    logic en_bit;
    logic [3:0] cmd_bits;
    logic [2:0] arm_cnt;
    logic [2:0] lpm_cnt;
    logic [31:0] prog_cnt;
    logic [7:0] lock_bits;
    logic [15:0] page_buf [`SPF_PAGE_WORDS];
    logic [`SPF_PAGE_WORDS-1:0] buf_valid;

    function automatic logic pattern_ok(input logic [4:0] p);
        return p == `SPF_PAT_REEN || p == `SPF_PAT_LOCK || p == `SPF_PAT_PGWR ||
               p == `SPF_PAT_PGER || p == `SPF_PAT_FILL;
    endfunction : pattern_ok

    // accepted low-bit pattern to the command that the next store carries out
    function automatic spf_op_e op_of(input logic [4:0] p);
        unique case (p)
            `SPF_PAT_REEN: return SPF_OP_REEN;
            `SPF_PAT_LOCK: return SPF_OP_LOCK;
            `SPF_PAT_PGWR: return SPF_OP_WRITE;
            `SPF_PAT_PGER: return SPF_OP_ERASE;
            default: return SPF_OP_FILL;
        endcase
    endfunction : op_of

    // pointer decode; bit 15 and bit 0 never reach the array
    wire [7:0] page_sel = i_cpu.z[14:7];
    wire [PW-1:0] word_sel = i_cpu.z[6:1];
    wire page_in_no_read_while_write_section = page_sel >= `SPF_NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE;
    wire csr_sel = i_reg.addr == `SPF_CSR_ADDR;
    wire csr_wr = i_reg.wr && csr_sel;
    wire [4:0] wr_low = i_reg.wdata[4:0];
    // command writes ignored while an operation runs so the enable bit holds
    wire wr_take = csr_wr && pattern_ok(wr_low) && state != SPF_BUSY;
    wire armed = state == SPF_ARMED;
    wire store_hit = armed && i_cpu.store;
    wire arm_lapse = armed && arm_cnt == 3'(`SPF_ARM_CYCLES - 1) && !i_cpu.store;
    wire prog_done = state == SPF_BUSY && prog_cnt == PROG_CYCLES - 1;
    wire fill_hit = store_hit && op == SPF_OP_FILL;
    wire reen_hit = store_hit && op == SPF_OP_REEN;
    wire start_prog = store_hit && (op == SPF_OP_ERASE || op == SPF_OP_WRITE);
    wire start_lock = store_hit && op == SPF_OP_LOCK;
    wire loading = |buf_valid;
    // re-enable written mid-load drops the buffer
    wire buf_abort = wr_take && wr_low == `SPF_PAT_REEN && loading;
    wire buf_clear = buf_abort || (prog_done && op == SPF_OP_WRITE);
    wire [7:0] csr_value = {irq_en, busy_flag, 1'b0, cmd_bits, en_bit};
    wire lpm_window = lpm_cnt != 3'h0;
    wire [1:0] bsz = i_boot_size_select;
    // larger section for smaller code; top of 16k words
    wire [13:0] boot_start = (bsz == 2'h3) ? 14'h3f00 : (bsz == 2'h2) ? 14'h3e00 :
                             (bsz == 2'h1) ? 14'h3c00 : 14'h3800;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= SPF_IDLE;
            op <= SPF_OP_FILL;
            arm_cnt <= 3'h0;
            prog_cnt <= '0;
        end else begin
            unique case (state)
                SPF_IDLE: begin
                    if (wr_take) begin
                        state <= SPF_ARMED;
                        arm_cnt <= 3'h0;
                        op <= op_of(wr_low);
                    end
                end
                SPF_ARMED: begin
                    arm_cnt <= arm_cnt + 3'h1;
                    if (start_prog || start_lock) begin
                        state <= SPF_BUSY;
                        prog_cnt <= '0;
                    end else if (store_hit) begin
                        state <= SPF_IDLE;
                    end else if (wr_take) begin
                        // a fresh write restarts the window with the new command
                        arm_cnt <= 3'h0;
                        op <= op_of(wr_low);
                    end else if (arm_lapse) begin
                        state <= SPF_IDLE;
                    end
                end
                SPF_BUSY: begin
                    prog_cnt <= prog_cnt + 32'h1;
                    if (prog_done) begin
                        state <= SPF_IDLE;
                    end
                end
                default: state <= SPF_IDLE;
            endcase
        end
    end

    // csr bits mirror the command state
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_en <= 1'b0;
            en_bit <= 1'b0;
            cmd_bits <= 4'h0;
        end else begin
            if (csr_wr) begin
                irq_en <= i_reg.wdata[`SPF_BIT_IRQ_EN];
            end
            if (wr_take) begin
                en_bit <= 1'b1;
                cmd_bits <= wr_low[4:1];
            end else if ((armed && (store_hit && !start_prog && !start_lock || arm_lapse))
                         || prog_done) begin
                en_bit <= 1'b0;
                cmd_bits <= 4'h0;
            end
        end
    end

    // busy: set wins over clear, clear by re-enable after completion or fill
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            busy_flag <= 1'b0;
        end else if (start_prog && !page_in_no_read_while_write_section) begin
            busy_flag <= 1'b1;
        end else if (reen_hit || fill_hit) begin
            busy_flag <= 1'b0;
        end
    end

    // temporary page buffer
    generate
        for (genvar w = 0; w < `SPF_PAGE_WORDS; w++) begin : g_buf
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    page_buf[w] <= 16'hffff;
                    buf_valid[w] <= 1'b0;
                end else if (fill_hit && word_sel == PW'(w)) begin
                    page_buf[w] <= i_cpu.data;
                    buf_valid[w] <= 1'b1;
                end else if (buf_clear) begin
                    page_buf[w] <= 16'hffff;
                    buf_valid[w] <= 1'b0;
                end
            end
        end
    endgenerate

    // lock byte and special load window
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lock_bits <= 8'hff;
            lpm_cnt <= 3'h0;
        end else begin
            if (prog_done && op == SPF_OP_LOCK) begin
                lock_bits <= lock_bits & i_cpu.data[7:0];
            end
            if (wr_take && wr_low == `SPF_PAT_LOCK) begin
                lpm_cnt <= 3'(`SPF_LPM_CYCLES);
            end else if (lpm_window) begin
                lpm_cnt <= lpm_cnt - 3'h1;
            end
        end
    end

    // read data stands only in the cycle after the strobe; unmapped reads give zero
    wire [7:0] rd_value = (i_reg.rd && csr_sel) ? csr_value : 8'h00;
    // fuse bytes are fixed parameters; only the lock byte is writable here
    wire [7:0] lpm_byte = i_cpu.z[0] ? FUSE_HIGH : (i_cpu.z[1] ? FUSE_LOW : lock_bits);
    wire rww_start = start_prog && !page_in_no_read_while_write_section;
    wire no_read_while_write_section_start = start_prog && page_in_no_read_while_write_section;

    // register port and interrupt outputs
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= `SPF_CSR_RESET;
            o_ready_irq <= 1'b0;
            o_boot_reset_addr <= 14'h3800;
        end else begin
            o_rdata <= rd_value;
            o_ready_irq <= irq_en && i_global_irq_en && !en_bit;
            o_boot_reset_addr <= boot_start;
        end
    end

    // cpu side outputs
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cpu_stall <= 1'b0;
            o_lpm_special <= 1'b0;
            o_lpm_data <= 8'h00;
            o_rww_blocked <= 1'b0;
        end else begin
            // stall whole operation on the section the cpu runs
            if (no_read_while_write_section_start) begin
                o_cpu_stall <= 1'b1;
            end else if (prog_done) begin
                o_cpu_stall <= 1'b0;
            end
            o_lpm_special <= lpm_window && i_cpu.load;
            o_lpm_data <= lpm_byte;
            o_rww_blocked <= busy_flag || rww_start;
        end
    end

    // flash array side outputs
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_flash_op <= '0;
            o_flash_wdata <= 16'h0000;
            o_flash_word <= 6'h00;
            o_lock_wr <= 1'b0;
            o_lock_byte <= 8'hff;
        end else begin
            o_flash_op.req <= start_prog;
            o_flash_op.erase <= op == SPF_OP_ERASE;
            if (start_prog) begin
                o_flash_op.page <= page_sel;
            end
            o_flash_wdata <= page_buf[word_sel];
            o_flash_word <= word_sel;
            o_lock_wr <= prog_done && op == SPF_OP_LOCK;
            o_lock_byte <= lock_bits;
        end
    end

endmodule : spf_ctrl

// ---- core/spf_consts.svh ----
// constants for the self-programming flash control block
`ifndef SPF_CONSTS_SVH
`define SPF_CONSTS_SVH
`define SPF_CSR_ADDR 6'h37
`define SPF_CSR_RESET 8'h00
`define SPF_BIT_IRQ_EN 7
`define SPF_BIT_BUSY 6
`define SPF_BIT_REEN 4
`define SPF_BIT_LOCK 3
`define SPF_BIT_PGWR 2
`define SPF_BIT_PGER 1
`define SPF_BIT_EN 0
`define SPF_PAT_REEN 5'h11
`define SPF_PAT_LOCK 5'h09
`define SPF_PAT_PGWR 5'h05
`define SPF_PAT_PGER 5'h03
`define SPF_PAT_FILL 5'h01
`define SPF_ARM_CYCLES 4
`define SPF_LPM_CYCLES 3
`define SPF_PC_WIDTH 14
`define SPF_PAGE_WORDS 64
`define SPF_NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE 8'he0
`define SPF_CLK_HZ 20000000
`define SPF_PROG_MIN_US 3700
`define SPF_PROG_MAX_US 4500
`define SPF_PROG_CYCLES ((`SPF_PROG_MIN_US * (`SPF_CLK_HZ / 1000000)))
`endif

// ---- core/spf_pkg.sv ----
// types for the self-programming flash control block
package spf_pkg;
    typedef enum logic [2:0] {
        SPF_IDLE, SPF_ARMED, SPF_BUSY
    } spf_state_e;
    typedef enum logic [2:0] {
        SPF_OP_FILL, SPF_OP_ERASE, SPF_OP_WRITE, SPF_OP_LOCK, SPF_OP_REEN
    } spf_op_e;
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } spf_reg_req_s;
    typedef struct packed {
        logic [15:0] z;
        logic [15:0] data;
        logic store;
        logic load;
    } spf_cpu_req_s;
    typedef struct packed {
        logic req;
        logic erase;
        logic [7:0] page;
    } spf_flash_op_s;
endpackage : spf_pkg

// ---- testbench/spf_ctrl_monitor.sv ----
// assertion checker for the flash control
`timescale 1ns/100ps
`include "spf_consts.svh"
module spf_ctrl_monitor #(
    parameter int PROG_CYCLES = 20,
    parameter logic [7:0] FUSE_HIGH = 8'hd9
) (
    // clock, reset, inputs
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire spf_pkg::spf_reg_req_s i_reg,
    input wire spf_pkg::spf_cpu_req_s i_cpu,
    input wire logic i_global_irq_en,
    input wire logic [1:0] i_boot_size_select,
    // watched outputs
    input wire logic [7:0] o_rdata,
    input wire logic o_cpu_stall,
    input wire logic o_ready_irq,
    input wire logic o_lpm_special,
    input wire logic [7:0] o_lpm_data,
    input wire logic o_rww_blocked,
    input wire logic [13:0] o_boot_reset_addr,
    input wire spf_pkg::spf_flash_op_s o_flash_op,
    input wire logic o_lock_wr,
    input wire logic [7:0] o_lock_byte
);
    import spf_pkg::*;
    int stall_cnt;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) stall_cnt <= 0;
        else stall_cnt <= o_cpu_stall ? stall_cnt + 1 : 0;
    end
    AST_NO_READ_WHILE_WRITE_SECTION_STALL: assert property (o_flash_op.req && o_flash_op.page >= 8'he0 |-> o_cpu_stall)
        else $error("no_read_while_write_section op without stall");
    AST_RWW_BUSY: assert property (o_flash_op.req && o_flash_op.page < 8'he0 |-> o_rww_blocked)
        else $error("rww op without busy");
    AST_PAGE_FIELD: assert property (o_flash_op.req |-> o_flash_op.page == $past(i_cpu.z[14:7]))
        else $error("page field wrong");
    AST_IRQ_COND: assert property (o_ready_irq |-> $past(i_global_irq_en) && !o_cpu_stall)
        else $error("ready irq without cause");
    AST_PROG_TIME: assert property ($fell(o_cpu_stall) |-> stall_cnt >= PROG_CYCLES - 1
        && stall_cnt <= PROG_CYCLES * `SPF_PROG_MAX_US / `SPF_PROG_MIN_US + 1)
        else $error("programming time out of range");
    AST_LOCK_ONLY: assert property ($changed(o_lock_byte) |-> o_lock_wr || $past(o_lock_wr))
        else $error("lock byte changed without write");
    AST_RD_ONLY: assert property (o_rdata != 8'h00 |-> $past(i_reg.rd)
        && $past(i_reg.addr) == `SPF_CSR_ADDR) else $error("read data outside read slot");
    AST_LPM_LOAD: assert property (o_lpm_special |-> $past(i_cpu.load))
        else $error("special load without load");
    AST_LPM_FUSE: assert property (o_lpm_special && $past(i_cpu.z[0]) |-> o_lpm_data == FUSE_HIGH)
        else $error("special load byte wrong");
    AST_BOOT: assert property (1'b1 |=> o_boot_reset_addr
        == 14'h0 - (14'h100 << ~$past(i_boot_size_select))) else $error("boot address wrong");
    COV_ERASE: cover property (o_flash_op.req && o_flash_op.erase);
    COV_STALL: cover property ($fell(o_cpu_stall));
    COV_LPM: cover property (o_lpm_special);
endmodule : spf_ctrl_monitor
bind spf_ctrl spf_ctrl_monitor #(.PROG_CYCLES(PROG_CYCLES), .FUSE_HIGH(FUSE_HIGH)) u_mon (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg(i_reg), .i_cpu(i_cpu),
    .i_global_irq_en(i_global_irq_en), .i_boot_size_select(i_boot_size_select),
    .o_rdata(o_rdata), .o_cpu_stall(o_cpu_stall), .o_ready_irq(o_ready_irq),
    .o_lpm_special(o_lpm_special), .o_lpm_data(o_lpm_data), .o_rww_blocked(o_rww_blocked),
    .o_boot_reset_addr(o_boot_reset_addr), .o_flash_op(o_flash_op),
    .o_lock_wr(o_lock_wr), .o_lock_byte(o_lock_byte));

// ---- testbench/spf_cpu_model.sv ----
// behavioural cpu core issuing store and load requests
`timescale 1ns/100ps
module spf_cpu_model (
    // clock and halt
    input wire logic i_clk,
    input wire logic i_stall,
    // request
    output spf_pkg::spf_cpu_req_s o_cpu
);
    import spf_pkg::*;
    initial o_cpu = '0;
    // a halted core issues nothing; data held after a store
    task automatic issue(input logic [15:0] z, input logic [15:0] dat, input logic st);
        while (i_stall) @(posedge i_clk);
        @(posedge i_clk);
        o_cpu.z <= st ? {z[15:1], 1'b0} : z;
        o_cpu.data <= dat;
        o_cpu.store <= st;
        o_cpu.load <= !st;
        @(posedge i_clk);
        o_cpu.store <= 1'b0;
        o_cpu.load <= 1'b0;
    endtask : issue
endmodule : spf_cpu_model

// ---- testbench/testbench.sv ----
// self-checking bench for the flash control
`timescale 1ns/100ps
`include "spf_consts.svh"
module testbench;
    import spf_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_global_irq_en = 1'b0;
    logic [1:0] i_boot_size_select = 2'b10;
    spf_reg_req_s i_reg = '0;
    spf_cpu_req_s cpu_req;
    spf_flash_op_s o_flash_op;
    logic [7:0] o_rdata, o_lpm_data, o_lock_byte, d;
    logic o_cpu_stall, o_ready_irq, o_lpm_special, o_rww_blocked, o_lock_wr;
    logic [13:0] o_boot_reset_addr;
    logic [15:0] o_flash_wdata;
    logic [5:0] o_flash_word;
    int failures = 0;
    int checked = 0;
    int n_stall;
    localparam int SIM_PROG = 20;
    initial begin
        forever #25 i_clk = ~i_clk;
    end
    spf_ctrl #(.PROG_CYCLES(SIM_PROG), .FUSE_HIGH(8'h5a)) uut (.i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_reg(i_reg), .o_rdata(o_rdata), .i_cpu(cpu_req), .i_global_irq_en(i_global_irq_en),
        .i_boot_size_select(i_boot_size_select), .o_cpu_stall(o_cpu_stall),
        .o_ready_irq(o_ready_irq), .o_lpm_special(o_lpm_special), .o_lpm_data(o_lpm_data),
        .o_rww_blocked(o_rww_blocked), .o_boot_reset_addr(o_boot_reset_addr),
        .o_flash_op(o_flash_op), .o_flash_wdata(o_flash_wdata), .o_flash_word(o_flash_word),
        .o_lock_wr(o_lock_wr), .o_lock_byte(o_lock_byte));
    spf_cpu_model cpu (.i_clk(i_clk), .i_stall(o_cpu_stall), .o_cpu(cpu_req));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] v);
        @(posedge i_clk);
        i_reg <= '{addr: `SPF_CSR_ADDR, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        i_reg.wr <= 1'b0;
    endtask : wr
    task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_reg <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        i_reg.rd <= 1'b0;
        @(negedge i_clk);
        d = o_rdata;
        if (exp != 8'hee) chk("csr", {8'h00, exp}, {8'h00, d});
    endtask : rchk
    // poll until the enable bit and command bits 3 to 1 read clear, giving up after 100 reads
    task automatic wait_idle;
        int n = 0;
        do begin
            rchk(`SPF_CSR_ADDR, 8'hee);
            n++;
        end while ((d & 8'h0f) != 8'h00 && n < 100);
        if ((d & 8'h0f) != 8'h00) failures++;
    endtask : wait_idle
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    initial begin
        #(50 * 20000);
        failures++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rchk(`SPF_CSR_ADDR, `SPF_CSR_RESET);
        rchk(6'h00, 8'h00);
        chk("lock", 8'hff, o_lock_byte);
        chk("boot", 14'h3e00, o_boot_reset_addr);
        wr(8'h01);
        cpu.issue(16'h800a, 16'habcd, 1'b1);
        repeat (2) @(negedge i_clk);
        chk("word", 6'h05, o_flash_word);
        chk("wdata", 16'habcd, o_flash_wdata);
        rchk(`SPF_CSR_ADDR, 8'h00);
        wr(8'h15);
        rchk(`SPF_CSR_ADDR, 8'h00);
        wr(8'h07);
        rchk(`SPF_CSR_ADDR, 8'h00);
        wr(8'h1f);
        rchk(`SPF_CSR_ADDR, 8'h00);
        wr(8'h01);
        repeat (5) @(posedge i_clk);
        rchk(`SPF_CSR_ADDR, 8'h00);
        $display("test fill and patterns done");
        wr(8'h03);
        cpu.issue(16'h0180, 16'h0000, 1'b1);
        @(negedge i_clk);
        chk("erase op", 16'h0303, o_flash_op);
        rchk(`SPF_CSR_ADDR, 8'h43);
        chk("blocked", 1'b1, o_rww_blocked);
        wr(8'h11);
        cpu.issue(16'h0000, 16'h0000, 1'b1);
        rchk(`SPF_CSR_ADDR, 8'h43);
        wait_idle();
        rchk(`SPF_CSR_ADDR, 8'h40);
        wr(8'h11);
        cpu.issue(16'h0000, 16'h0000, 1'b1);
        rchk(`SPF_CSR_ADDR, 8'h00);
        cpu.issue(16'h000a, 16'h0000, 1'b0);
        @(negedge i_clk);
        chk("discard", 16'hffff, o_flash_wdata);
        $display("test erase done");
        wr(8'h05);
        cpu.issue(16'hf280, 16'hffff, 1'b1);
        @(negedge i_clk);
        chk("stall", 1'b1, o_cpu_stall);
        chk("write op", 16'h02e5, o_flash_op);
        n_stall = 0;
        while (o_cpu_stall && n_stall < 100) begin
            @(negedge i_clk);
            n_stall++;
        end
        chk("stall cycles", 16'(SIM_PROG), 16'(n_stall));
        rchk(`SPF_CSR_ADDR, 8'h00);
        $display("test write done");
        wr(8'h09);
        cpu.issue(16'h0001, 16'h0000, 1'b0);
        @(negedge i_clk);
        chk("fuse", 8'h5a, o_lpm_data);
        chk("special", 1'b1, o_lpm_special);
        repeat (6) @(posedge i_clk);
        wr(8'h09);
        cpu.issue(16'h0000, 16'h12c3, 1'b1);
        wait_idle();
        chk("lock", 8'hc3, o_lock_byte);
        $display("test lock done");
        wr(8'h80);
        i_global_irq_en <= 1'b1;
        repeat (2) @(negedge i_clk);
        chk("irq", 1'b1, o_ready_irq);
        wr(8'h81);
        repeat (2) @(negedge i_clk);
        chk("irq", 1'b0, o_ready_irq);
        repeat (6) @(negedge i_clk);
        chk("irq", 1'b1, o_ready_irq);
        @(posedge i_clk);
        i_boot_size_select <= 2'b01;
        repeat (2) @(negedge i_clk);
        chk("boot", 14'h3c00, o_boot_reset_addr);
        $display("test irq and boot done");
        conclude();
    end
endmodule : testbench
